//--- dv/fail_safe_state_machine_config_bench.sv
// Self-checking bench for the fail-safe machine configuration block
`timescale 1ns/100ps
module fail_safe_state_machine_config_bench;
  import fssc_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        reg_wr, reg_rd, reg_rvalid, reset_out_n, clock_monitor_en, long_low_timeout, vld;
  logic [15:0] reg_wdata, reg_rdata, rd, w, n;
  logic [3:0]  fault_count = 4'h0;
  logic        reset_request = 1'b0;
  logic        short_high_detect = 1'b0;
  logic        reset_hold = 1'b0;
  logic [1:0]  fault_counter_limit, fault_impact_select;
  integer      fail_count = 0;
  integer      compares = 0;
  integer      seed = 60197;
  // Pulse table: written word, trigger by short, expected low cycles
  logic [15:0] tw [5] = '{16'h0000, 16'h0200, 16'h0000, 16'h0080, 16'h0280};
  logic        ts [5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [15:0] tn [5] = '{16'h0014, 16'h0005, 16'h0000, 16'h0014, 16'h0005};

  always #2 clk_sys = ~clk_sys;

  fssc_host host (.clk_sys(clk_sys), .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));

  // Short counts keep the run brief
  fssc_config #(.PULSE_LONG_CYCLES(32'h14), .PULSE_SHORT_CYCLES(32'h5), .LONG_LOW_CYCLES(32'h32)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fault_count(fault_count),
    .reset_request(reset_request), .short_high_detect(short_high_detect), .reset_hold(reset_hold),
    .reset_out_n(reset_out_n), .clock_monitor_en(clock_monitor_en), .long_low_timeout(long_low_timeout),
    .fault_counter_limit(fault_counter_limit), .fault_impact_select(fault_impact_select));

  // Writable bits kept, reserved bits zero, count clamped at twelve
  function automatic logic [15:0] exp_read(input logic [15:0] wd, input logic [3:0] c);
    return (wd & 16'hdab0) | {12'h000, (c > 4'hc) ? 4'hc : c};
  endfunction

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic tally_and_finish;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One-cycle trigger, by request or by short to high
  task automatic fire(input logic by_short);
    @(posedge clk_sys);
    if (by_short) short_high_detect <= 1'b1;
    else reset_request <= 1'b1;
    @(posedge clk_sys);
    short_high_detect <= 1'b0;
    reset_request     <= 1'b0;
  endtask

  // Counts low cycles of the reset output; window outlasts the long pulse
  task automatic pulse_len(output logic [15:0] cnt);
    cnt = 16'h0000;
    repeat (40) begin
      #1;
      if (reset_out_n === 1'b0) cnt = cnt + 16'h0001;
      @(posedge clk_sys);
    end
  endtask

  // Config readback, outputs and live count; also checks power-on defaults
  task automatic check_cfg(input logic [15:0] wd);
    host.rd_reg(rd, vld);
    cmp_bit(vld, 1'b1);
    cmp_word(rd, exp_read(wd, fault_count));
    cmp_word({14'h0000, fault_counter_limit}, {14'h0000, wd[15:14]});
    cmp_word({14'h0000, fault_impact_select}, {14'h0000, wd[12:11]});
    cmp_bit(clock_monitor_en, ~wd[5]);
  endtask

  // Watchdog sized well beyond the expected run
  initial begin
    #200000;
    fail_count++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    check_cfg(16'h4800);
    // Every count value first, then random words and counts
    for (int i = 0; i < 36; i++) begin
      w = (i < 16) ? (i[0] ? 16'hffff : 16'h0000) : 16'($random(seed));
      @(posedge clk_sys);
      fault_count <= (i < 16) ? i[3:0] : 4'($random(seed));
      host.wr_reg(w);
      check_cfg(w);
    end
    // Pulse lengths and the short-to-high enable
    for (int k = 0; k < 5; k++) begin
      host.wr_reg(tw[k]);
      fire(ts[k]);
      pulse_len(n);
      cmp_word(n, tn[k]);
    end
    // Random short-to-high levels while masked never pull reset
    host.wr_reg(16'h0000);
    repeat (30) begin
      @(posedge clk_sys);
      short_high_detect <= 1'($random(seed));
      #1;
      cmp_bit(reset_out_n, 1'b1);
    end
    @(posedge clk_sys);
    short_high_detect <= 1'b0;
    // Long reset-low timer: not before the count, set after, cleared by disable
    host.wr_reg(16'h0000);
    @(posedge clk_sys);
    reset_hold <= 1'b1;
    fire(1'b0);
    repeat (40) @(posedge clk_sys);
    #1;
    cmp_bit(reset_out_n, 1'b0);
    cmp_bit(long_low_timeout, 1'b0);
    repeat (20) @(posedge clk_sys);
    #1;
    cmp_bit(long_low_timeout, 1'b1);
    host.wr_reg(16'h0010);
    @(posedge clk_sys);
    #1;
    cmp_bit(long_low_timeout, 1'b0);
    reset_hold <= 1'b0;
    repeat (30) @(posedge clk_sys);
    // Reset in mid-run brings defaults back
    host.wr_reg(16'hffff);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n     <= 1'b1;
    fault_count <= 4'h0;
    check_cfg(16'h4800);
    cmp_bit(reset_out_n, 1'b1);
    tally_and_finish();
  end
endmodule

//--- dv/fssc_host.sv
// Host model that reaches the configuration register through its strobed word port
`timescale 1ns/100ps
module fssc_host (
  input  wire logic        clk_sys,    // System clock
  input  wire logic        reg_rvalid, // Read data valid
  input  wire logic [15:0] reg_rdata,  // Read data
  output logic             reg_wr,     // Write strobe
  output logic             reg_rd,     // Read strobe
  output logic      [15:0] reg_wdata   // Write data
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 16'h0000;
  end
  // One-cycle write strobe, data held with it
  task automatic wr_reg(input logic [15:0] data);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_wdata <= data;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  // Read answer lands on the same edge that takes the strobe
  task automatic rd_reg(output logic [15:0] data, output logic valid);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    data  = reg_rdata;
    valid = reg_rvalid;
  endtask
endmodule

//--- hw/fssc_config.sv
// Fail-safe machine configuration register, reset pulse generator and long reset-low timer
`timescale 1ns/100ps
`include "fssc_defs.svh"
module fssc_config
  import fssc_pkg::*;
#(
  parameter logic [31:0] PULSE_LONG_CYCLES  = 32'(`FSSC_PULSE_LONG_CYC),  // 10 ms pulse
  parameter logic [31:0] PULSE_SHORT_CYCLES = 32'(`FSSC_PULSE_SHORT_CYC), // 1.0 ms pulse
  parameter logic [31:0] LONG_LOW_CYCLES    = 32'(`FSSC_LONG_LOW_CYC)     // 8 s reset low
) (
  input  wire logic        clk_sys,             // System clock, 250 MHz
  input  wire logic        reset_n,             // Power-on reset, synchronous, active low
  input  wire logic        reg_wr,              // Register write strobe, one cycle
  input  wire logic        reg_rd,              // Register read strobe, one cycle
  input  wire logic [15:0] reg_wdata,           // Write data, bit 0 is register bit 8
  output logic      [15:0] reg_rdata,           // Read data, bit 0 is register bit 8
  output logic             reg_rvalid,          // Read data valid, one cycle
  input  wire logic [3:0]  fault_count,         // Live fault error counter
  input  wire logic        reset_request,       // Reset pulse request from the machine
  input  wire logic        short_high_detect,   // Short to high seen on safe output
  input  wire logic        reset_hold,          // External hold of reset low
  output logic             reset_out_n,         // Reset output, active low
  output logic             clock_monitor_en,    // Clock monitoring enabled
  output logic             long_low_timeout,    // Reset held low for 8 s
  output logic [1:0]       fault_counter_limit, // Fault counter limit setting
  output logic [1:0]       fault_impact_select  // Fault impact setting
);
  localparam fssc_cfg_type CFG_DEFAULT = '{
    fault_counter_limit:          `FSSC_LIMIT_RST,
    fault_impact_select:          `FSSC_IMPACT_RST,
    reset_pulse_length_sel:       `FSSC_BIT_RST,
    safe_out_short_high_reset_en: `FSSC_BIT_RST,
    clock_monitor_disable:        `FSSC_BIT_RST,
    long_reset_timer_disable:     `FSSC_BIT_RST
  };

  fssc_cfg_type         cfg;
  fssc_cfg_type         next_cfg;
  logic [15:0]          next_reg_rdata;
  logic                 next_reg_rvalid;
  logic [3:0]           fault_live;
  fssc_pulse_state_type state;
  fssc_pulse_state_type next_state;
  logic [31:0]          pulse_limit;
  logic [31:0]          next_pulse_limit;
  logic                 next_reset_out_n;
  logic                 trigger;
  logic                 pulse_done;
  logic                 long_run;
  logic                 long_expired;
  logic                 next_long_low_timeout;
  logic                 next_clock_monitor_en;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration register

  // Fields change only on a write
  always_comb begin
    next_cfg = cfg;
    if (reg_wr) begin
      next_cfg.fault_counter_limit          = reg_wdata[`FSSC_LIMIT_LSB - `FSSC_FIELD_BASE +: 2];
      next_cfg.fault_impact_select          = reg_wdata[`FSSC_IMPACT_LSB - `FSSC_FIELD_BASE +: 2];
      next_cfg.reset_pulse_length_sel       = reg_wdata[`FSSC_PULSE_SEL_POS - `FSSC_FIELD_BASE];
      next_cfg.safe_out_short_high_reset_en = reg_wdata[`FSSC_SHORT_EN_POS - `FSSC_FIELD_BASE];
      next_cfg.clock_monitor_disable        = reg_wdata[`FSSC_CLKMON_DIS_POS - `FSSC_FIELD_BASE];
      next_cfg.long_reset_timer_disable     = reg_wdata[`FSSC_LONG_DIS_POS - `FSSC_FIELD_BASE];
    end
  end

  // Defaults at power-on reset, otherwise take next_cfg
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg <= CFG_DEFAULT;
    end else begin
      cfg <= next_cfg;
    end
  end

  assign fault_counter_limit = cfg.fault_counter_limit;
  assign fault_impact_select = cfg.fault_impact_select;

  ////////////////////////////////////////////////////////////////////////////////
  // Readback

  // Clamp guards against an out-of-range count from the machine
  assign fault_live = (fault_count > `FSSC_COUNT_MAX) ? `FSSC_COUNT_MAX : fault_count;

  // Reserved and unused bits stay zero; count sampled at the read itself
  always_comb begin
    next_reg_rdata  = reg_rdata;
    next_reg_rvalid = reg_rd;
    if (reg_rd) begin
      next_reg_rdata = 16'h0;
      next_reg_rdata[`FSSC_LIMIT_LSB - `FSSC_FIELD_BASE +: 2]  = cfg.fault_counter_limit;
      next_reg_rdata[`FSSC_IMPACT_LSB - `FSSC_FIELD_BASE +: 2] = cfg.fault_impact_select;
      next_reg_rdata[`FSSC_PULSE_SEL_POS - `FSSC_FIELD_BASE]   = cfg.reset_pulse_length_sel;
      next_reg_rdata[`FSSC_SHORT_EN_POS - `FSSC_FIELD_BASE]    = cfg.safe_out_short_high_reset_en;
      next_reg_rdata[`FSSC_CLKMON_DIS_POS - `FSSC_FIELD_BASE]  = cfg.clock_monitor_disable;
      next_reg_rdata[`FSSC_LONG_DIS_POS - `FSSC_FIELD_BASE]    = cfg.long_reset_timer_disable;
      next_reg_rdata[`FSSC_COUNT_LSB - `FSSC_FIELD_BASE +: 4]  = fault_live;
    end
  end

  // Read data register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      reg_rdata  <= 16'h0;
      reg_rvalid <= 1'h0;
    end else begin
      reg_rdata  <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset pulse generator

  // Short-to-high only counts when enabled
  assign trigger = reset_request || (cfg.safe_out_short_high_reset_en && short_high_detect);

  // Length latched at pulse start so a write mid-pulse cannot cut it short
  always_comb begin
    next_state       = state;
    next_pulse_limit = pulse_limit;
    case (state)
      FSSC_IDLE: begin
        if (trigger) begin
          next_state       = FSSC_PULSE;
          next_pulse_limit = cfg.reset_pulse_length_sel ? PULSE_SHORT_CYCLES : PULSE_LONG_CYCLES;
        end
      end
      FSSC_PULSE: begin
        if (pulse_done) begin
          next_state = FSSC_IDLE;
        end
      end
      default: begin
        next_state = FSSC_IDLE;
      end
    endcase
    next_reset_out_n = (next_state != FSSC_PULSE) && !reset_hold;
  end

  // Pulse state register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state       <= FSSC_IDLE;
      pulse_limit <= 32'h1;
      reset_out_n <= 1'h1;
    end else begin
      state       <= next_state;
      pulse_limit <= next_pulse_limit;
      reset_out_n <= next_reset_out_n;
    end
  end

  fssc_timer u_pulse_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .run     (state == FSSC_PULSE),
    .limit   (pulse_limit),
    .expired (pulse_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Long reset-low timer and clock monitor enable

  // Counting stops and restarts whenever disabled
  assign long_run = !reset_out_n && !cfg.long_reset_timer_disable;

  fssc_timer u_long_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .run     (long_run),
    .limit   (LONG_LOW_CYCLES),
    .expired (long_expired)
  );

  // Registered status outputs
  always_comb begin
    next_long_low_timeout = long_expired;
    next_clock_monitor_en = !next_cfg.clock_monitor_disable;
  end

  // Status output registers
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      long_low_timeout <= 1'h0;
      clock_monitor_en <= 1'h1;
    end else begin
      long_low_timeout <= next_long_low_timeout;
      clock_monitor_en <= next_clock_monitor_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [31:0] pulse_cycles;
  logic [31:0] next_pulse_cycles;

  // Cycles spent in the pulse so far, cleared outside it
  always_comb begin
    next_pulse_cycles = 32'h0;
    if (state == FSSC_PULSE) begin
      next_pulse_cycles = pulse_cycles + 32'h1;
    end
  end

  // Pulse cycle counter register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pulse_cycles <= 32'h0;
    end else begin
      pulse_cycles <= next_pulse_cycles;
    end
  end

  a_pulse_length: assert property (@(posedge clk_sys) disable iff (!reset_n)
    $fell(state == FSSC_PULSE) |-> ($past(pulse_cycles) + 32'h1 == pulse_limit) &&
      (pulse_limit == PULSE_SHORT_CYCLES || pulse_limit == PULSE_LONG_CYCLES))
    else $error("reset pulse length wrong");

  a_pulse_select: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == FSSC_IDLE && trigger) |=>
      pulse_limit == ($past(cfg.reset_pulse_length_sel) ? PULSE_SHORT_CYCLES : PULSE_LONG_CYCLES))
    else $error("reset pulse length select not applied");

  a_short_trigger: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == FSSC_IDLE && cfg.safe_out_short_high_reset_en && short_high_detect) |=> ##1 !reset_out_n)
    else $error("short to high did not assert reset");

  a_short_masked: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (state == FSSC_IDLE && !cfg.safe_out_short_high_reset_en && !reset_request) |=> state == FSSC_IDLE)
    else $error("masked short to high asserted reset");

  a_clock_monitor: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_wr |=> clock_monitor_en == !$past(reg_wdata[`FSSC_CLKMON_DIS_POS - `FSSC_FIELD_BASE]))
    else $error("clock monitor enable does not follow write");

  a_long_disabled: assert property (@(posedge clk_sys) disable iff (!reset_n)
    (cfg.long_reset_timer_disable && $past(cfg.long_reset_timer_disable)) |=> !long_low_timeout)
    else $error("long timer fired while disabled");

  a_long_fires: assert property (@(posedge clk_sys) disable iff (!reset_n)
    long_expired |=> long_low_timeout)
    else $error("long timer expiry not reported");

  a_fault_live: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rd |=> reg_rvalid && reg_rdata[3:0] == $past(fault_live) && reg_rdata[3:0] <= `FSSC_COUNT_MAX)
    else $error("fault counter readback not live");

  a_reserved_zero: assert property (@(posedge clk_sys) disable iff (!reset_n)
    reg_rvalid |-> (reg_rdata[13] == 1'h0 && reg_rdata[10] == 1'h0 && reg_rdata[8] == 1'h0 &&
      reg_rdata[6] == 1'h0))
    else $error("reserved bits not zero");

  a_cfg_default: assert property (@(posedge clk_sys)
    !reset_n |=> cfg == CFG_DEFAULT)
    else $error("configuration not at default after reset");

  a_cfg_hold: assert property (@(posedge clk_sys) disable iff (!reset_n)
    !reg_wr |=> $stable(cfg))
    else $error("configuration changed without write");
endmodule

//--- hw/fssc_defs.svh
// Bit positions, reset values and timing figures of the fail-safe machine configuration register
`ifndef FSSC_DEFS_SVH
`define FSSC_DEFS_SVH
// Register data port bit 0 carries register bit 8
`define FSSC_FIELD_BASE       8
`define FSSC_LIMIT_LSB        22
`define FSSC_IMPACT_LSB       19
`define FSSC_PULSE_SEL_POS    17
`define FSSC_SHORT_EN_POS     15
`define FSSC_CLKMON_DIS_POS   13
`define FSSC_LONG_DIS_POS     12
`define FSSC_COUNT_LSB        8
`define FSSC_COUNT_MAX        4'hc
`define FSSC_LIMIT_RST        2'h1
`define FSSC_IMPACT_RST       2'h1
`define FSSC_BIT_RST          1'h0
// Timing in printed units and clock rate
`define FSSC_CLK_KHZ          250000
`define FSSC_PULSE_LONG_MS    10
`define FSSC_PULSE_SHORT_US   1000
`define FSSC_LONG_LOW_S       8
`define FSSC_PULSE_LONG_CYC   (64'd`FSSC_PULSE_LONG_MS * 64'd`FSSC_CLK_KHZ)
`define FSSC_PULSE_SHORT_CYC  (64'd`FSSC_PULSE_SHORT_US * 64'd`FSSC_CLK_KHZ / 64'd1000)
`define FSSC_LONG_LOW_CYC     (64'd`FSSC_LONG_LOW_S * 64'd`FSSC_CLK_KHZ * 64'd1000)
`endif

//--- hw/fssc_pkg.sv
// Types shared by the fail-safe machine configuration block
package fssc_pkg;
  typedef struct packed {
    logic [1:0] fault_counter_limit;
    logic [1:0] fault_impact_select;
    logic       reset_pulse_length_sel;
    logic       safe_out_short_high_reset_en;
    logic       clock_monitor_disable;
    logic       long_reset_timer_disable;
  } fssc_cfg_type;

  typedef enum logic {
    FSSC_IDLE,
    FSSC_PULSE
  } fssc_pulse_state_type;
endpackage

//--- hw/fssc_timer.sv
// Saturating cycle counter that flags when a run has lasted a given number of cycles
`timescale 1ns/100ps
module fssc_timer (
  input  wire logic        clk_sys,  // System clock
  input  wire logic        reset_n,  // Synchronous reset, active low
  input  wire logic        run,      // Count while high, clear while low
  input  wire logic [31:0] limit,    // Cycles until expiry
  output logic             expired   // Run has lasted limit cycles
);
  logic [31:0] count;
  logic [31:0] next_count;

  // Saturate at expiry so a long hold keeps the flag up
  assign expired = run && (count == limit - 32'h1);

  // Next count
  always_comb begin
    next_count = count;
    if (!run) begin
      next_count = 32'h0;
    end else if (!expired) begin
      next_count = count + 32'h1;
    end
  end

  // Count register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      count <= 32'h0;
    end else begin
      count <= next_count;
    end
  end
endmodule
